//--- lwb_bridge_top.sv
// lwb_bridge_top: learning bridge between a lan mac byte stream and an hdlc wan byte stream
// assumes lan/wan streams are on clk_in; straps and phy status pins are asynchronous
//
// What this block does
// - filter strap off: every good lan frame arriving with the buffer free goes to wan, no address check.
// - filter strap on: destination checked against learned table before forwarding.
// - address table holds 256 entries, looked up for every received frame.
// - source addresses learned automatically; entries deleted 5 to 10 minutes after their last refresh.
// - negotiation-disable strap on: speed and duplex come from straps only.
// - negotiation enabled: use partner result; on failure 10 Mbps half duplex.
// - duplex strap off full, on half; ignored while negotiating.
// - speed strap on 10 Mbps, off 100 Mbps; ignored while negotiating.
// - crossover strap on hunts crossed pairs; off is fixed straight mdi.
// - flow strap on enables pause flow control in full duplex only; off disables it.
// - memory straps split packet buffers 308/32, 170/170, 32/308; both on reserved.
// - total packet buffering at most 340 packets.
// - undersize frames toward lan padded to minimum length.
// - reversed receive polarity detected and corrected.
// - wan frames hdlc framed, one frame latency.
`timescale 1ns/1ps
`default_nettype none
module lwb_bridge_top #(
  parameter int unsigned SEC_CYCLES = lwb_pkg::CLK_HZ
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       filter_enable_strap_in,
  input  wire logic       flow_control_strap_in,
  input  wire logic       negotiation_disable_strap_in,
  input  wire logic       duplex_select_strap_in,
  input  wire logic       speed_select_strap_in,
  input  wire logic       crossover_auto_strap_in,
  input  wire logic [1:0] memory_strap_in,
  input  wire logic       phy_link_in,
  input  wire logic       phy_an_done_in,
  input  wire logic       phy_an_ok_in,
  input  wire logic       phy_an_speed100_in,
  input  wire logic       phy_an_full_in,
  input  wire logic       phy_pol_reversed_in,
  input  wire logic       lan_rx_valid_in,
  input  wire logic [7:0] lan_rx_data_in,
  input  wire logic       lan_rx_last_in,
  input  wire logic       lan_rx_error_in,
  output logic            wan_tx_valid_out,
  output logic [7:0]      wan_tx_data_out,
  input  wire logic       wan_tx_ready_in,
  input  wire logic       wan_rx_valid_in,
  input  wire logic [7:0] wan_rx_data_in,
  input  wire logic       wan_rx_last_in,
  output logic            wan_rx_ready_out,
  output logic            lan_tx_valid_out,
  output logic [7:0]      lan_tx_data_out,
  output logic            lan_tx_last_out,
  input  wire logic       lan_tx_ready_in,
  output logic            an_enable_out,
  output logic            mdix_select_out,
  output logic            pol_invert_out,
  output logic            pause_request_out,
  output logic [8:0]      lan_to_wan_pkts_out,
  output logic [8:0]      wan_to_lan_pkts_out,
  output logic            memory_reserved_out,
  output logic            led_full_out,
  output logic            led_link_out,
  output logic            led_error_out,
  output logic            led_100m_out,
  output logic            led_rx_out,
  output logic            led_tx_out
);
  localparam int unsigned NSYNC = 14;
  logic [NSYNC-1:0] sync1_q, sync2_q, pins;
  assign pins = {filter_enable_strap_in, flow_control_strap_in, negotiation_disable_strap_in,
                 duplex_select_strap_in, speed_select_strap_in, crossover_auto_strap_in,
                 memory_strap_in, phy_link_in, phy_an_done_in, phy_an_ok_in,
                 phy_an_speed100_in, phy_an_full_in, phy_pol_reversed_in};
  always_ff @(posedge clk_in) begin
    sync1_q <= pins;
    sync2_q <= sync1_q;
  end
  logic filt_en, flow_en, neg_dis, dup_s, spd_s, xo_en, link, an_done, an_ok, an_100, an_full, pol_rev;
  logic [1:0] mem_cfg;
  assign {filt_en, flow_en, neg_dis, dup_s, spd_s, xo_en, mem_cfg,
          link, an_done, an_ok, an_100, an_full, pol_rev} = sync2_q;

  // one-second enable
  logic [31:0] sec_div_q;
  logic        sec_tick;
  assign sec_tick = (sec_div_q == SEC_CYCLES - 1);
  always_ff @(posedge clk_in) begin
    if (rst_in) sec_div_q <= 32'h0;
    else sec_div_q <= sec_tick ? 32'h0 : sec_div_q + 32'h1;
  end

  // lan link mode
  logic an_good, speed100_d, full_d;
  assign an_good    = an_done && an_ok;
  assign speed100_d = neg_dis ? !spd_s : (an_good && an_100);
  assign full_d     = neg_dis ? !dup_s : (an_good && an_full);

  // lan receive capture
  lwb_table_if tif ();
  lwb_mac_table u_table (.clk_in(clk_in), .rst_in(rst_in), .tbl(tif));
  logic [7:0]  buf_mem [lwb_pkg::BUF_BYTES];
  logic [10:0] rx_cnt_q, tx_len_q, rd_q;
  logic [47:0] dst_q, src_q;
  logic        drop_q, pend_q;
  logic        rx_sof, rx_end, frame_ok, fwd;
  assign rx_sof   = lan_rx_valid_in && (rx_cnt_q == 11'h000);
  assign rx_end   = lan_rx_valid_in && lan_rx_last_in;
  assign frame_ok = !drop_q && !(rx_sof && pend_q) && !lan_rx_error_in && (rx_cnt_q >= lwb_pkg::HDR_SRC_END);
  assign tif.lookup_mac  = dst_q;
  assign tif.learn_mac   = src_q;
  assign tif.learn_valid = rx_end && frame_ok && !src_q[40];
  assign tif.sec_tick    = sec_tick;
  assign fwd = !filt_en || !tif.lookup_hit;

  always_ff @(posedge clk_in) begin
    if (lan_rx_valid_in && !pend_q) buf_mem[rx_cnt_q] <= lan_rx_data_in;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rx_cnt_q <= 11'h000;
      dst_q    <= 48'h0;
      src_q    <= 48'h0;
      drop_q   <= 1'b0;
    end else if (lan_rx_valid_in) begin
      rx_cnt_q <= lan_rx_last_in ? 11'h000 : rx_cnt_q + 11'h001;
      if (rx_cnt_q < lwb_pkg::HDR_DST_END) dst_q <= {dst_q[39:0], lan_rx_data_in};
      else if (rx_cnt_q < lwb_pkg::HDR_SRC_END) src_q <= {src_q[39:0], lan_rx_data_in};
      // a frame arriving while the buffer is still owed to the wan is dropped whole
      if (rx_sof && pend_q) drop_q <= !lan_rx_last_in;
      else if (lan_rx_last_in) drop_q <= 1'b0;
    end
  end

  // wan transmit, hdlc flag and byte stuffing
  lwb_pkg::lwb_tx_state_t st_q;
  logic       adv;
  logic [7:0] rd_byte;
  assign adv     = !wan_tx_valid_out || wan_tx_ready_in;
  assign rd_byte = buf_mem[rd_q];
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q             <= lwb_pkg::LWB_TX_IDLE;
      pend_q           <= 1'b0;
      tx_len_q         <= 11'h000;
      rd_q             <= 11'h000;
      wan_tx_valid_out <= 1'b0;
      wan_tx_data_out  <= 8'h00;
    end else begin
      if (rx_end && frame_ok && fwd && !pend_q) begin
        pend_q   <= 1'b1;
        tx_len_q <= rx_cnt_q + 11'h001;
      end
      if (adv) begin
        case (st_q)
          lwb_pkg::LWB_TX_IDLE: begin
            wan_tx_valid_out <= pend_q;
            wan_tx_data_out  <= lwb_pkg::HDLC_FLAG;
            rd_q             <= 11'h000;
            if (pend_q) st_q <= lwb_pkg::LWB_TX_DATA;
          end
          lwb_pkg::LWB_TX_DATA: begin
            wan_tx_valid_out <= 1'b1;
            if (rd_q == tx_len_q) begin
              wan_tx_data_out <= lwb_pkg::HDLC_FLAG;
              st_q            <= lwb_pkg::LWB_TX_DONE;
            end else if (rd_byte == lwb_pkg::HDLC_FLAG || rd_byte == lwb_pkg::HDLC_ESC) begin
              wan_tx_data_out <= lwb_pkg::HDLC_ESC;
              st_q            <= lwb_pkg::LWB_TX_ESC;
            end else begin
              wan_tx_data_out <= rd_byte;
              rd_q            <= rd_q + 11'h001;
            end
          end
          lwb_pkg::LWB_TX_ESC: begin
            wan_tx_data_out <= rd_byte ^ lwb_pkg::HDLC_XOR;
            rd_q            <= rd_q + 11'h001;
            st_q            <= lwb_pkg::LWB_TX_DATA;
          end
          lwb_pkg::LWB_TX_DONE: begin
            wan_tx_valid_out <= 1'b0;
            pend_q           <= 1'b0;
            st_q             <= lwb_pkg::LWB_TX_IDLE;
          end
          default: begin
            wan_tx_valid_out <= 1'b0;
            st_q             <= lwb_pkg::LWB_TX_IDLE;
          end
        endcase
      end
    end
  end

  // wan to lan with padding
  logic        ladv, pad_q;
  logic [10:0] pcnt_q;
  assign ladv             = !lan_tx_valid_out || lan_tx_ready_in;
  assign wan_rx_ready_out = ladv && !pad_q;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      lan_tx_valid_out <= 1'b0;
      lan_tx_data_out  <= 8'h00;
      lan_tx_last_out  <= 1'b0;
      pad_q            <= 1'b0;
      pcnt_q           <= 11'h000;
    end else if (ladv) begin
      lan_tx_valid_out <= pad_q || wan_rx_valid_in;
      lan_tx_last_out  <= 1'b0;
      if (pad_q || wan_rx_valid_in) begin
        lan_tx_data_out <= pad_q ? 8'h00 : wan_rx_data_in;
        pcnt_q          <= pcnt_q + 11'h001;
        if (pad_q ? (pcnt_q == lwb_pkg::MIN_FRAME_BYTES - 11'h001) : wan_rx_last_in) begin
          if (!pad_q && pcnt_q < lwb_pkg::MIN_FRAME_BYTES - 11'h001) begin
            pad_q <= 1'b1;
          end else begin
            pad_q           <= 1'b0;
            lan_tx_last_out <= 1'b1;
            pcnt_q          <= 11'h000;
          end
        end
      end
    end
  end

  // buffer split, crossover hunt, polarity, flow control, leds
  logic [8:0] l2w, w2l;
  assign l2w = (mem_cfg == lwb_pkg::MEM_CFG_L2W) ? lwb_pkg::PKT_BUF_LARGE :
               (mem_cfg == lwb_pkg::MEM_CFG_EVEN) ? lwb_pkg::PKT_BUF_EVEN : lwb_pkg::PKT_BUF_SMALL;
  assign w2l = lwb_pkg::TOTAL_PKT_BUF - l2w;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mdix_select_out <= 1'b0;
      {an_enable_out, pol_invert_out, pause_request_out, memory_reserved_out} <= 4'h0;
      {lan_to_wan_pkts_out, wan_to_lan_pkts_out} <= 18'h0;
      {led_full_out, led_link_out, led_error_out, led_100m_out, led_rx_out, led_tx_out} <= 6'h00;
    end else begin
      if (!xo_en) mdix_select_out <= 1'b0;
      else if (!link && sec_tick) mdix_select_out <= !mdix_select_out;
      an_enable_out       <= !neg_dis;
      pol_invert_out      <= pol_rev;
      pause_request_out   <= flow_en && full_d && pend_q && lan_rx_valid_in;
      lan_to_wan_pkts_out <= l2w;
      wan_to_lan_pkts_out <= w2l;
      memory_reserved_out <= (mem_cfg == 2'h3);
      led_full_out  <= full_d;
      led_link_out  <= link;
      led_error_out <= lan_rx_error_in && lan_rx_valid_in;
      led_100m_out  <= speed100_d;
      led_rx_out    <= lan_rx_valid_in;
      led_tx_out    <= lan_tx_valid_out;
    end
  end

  sequence s_fwd_frame;
    rx_end && frame_ok && fwd && !pend_q;
  endsequence
  property p_fwd_starts;
    @(posedge clk_in) disable iff (rst_in) s_fwd_frame |=> pend_q;
  endproperty
  a_fwd_starts: assert property (p_fwd_starts) else $error("forwarded frame not queued");
  property p_filter_drop;
    @(posedge clk_in) disable iff (rst_in) rx_end && filt_en && tif.lookup_hit && !pend_q |=> !pend_q;
  endproperty
  a_filter_drop: assert property (p_filter_drop) else $error("lan-local frame sent to wan");
  property p_repeater;
    @(posedge clk_in) disable iff (rst_in) rx_end && frame_ok && !filt_en && !pend_q |=> pend_q;
  endproperty
  a_repeater: assert property (p_repeater) else $error("repeater mode dropped frame");
  property p_fallback;
    @(posedge clk_in) disable iff (rst_in) !neg_dis && !an_good |=> !led_full_out && !led_100m_out;
  endproperty
  a_fallback: assert property (p_fallback) else $error("no 10 half fallback");
  property p_straps;
    @(posedge clk_in) disable iff (rst_in) neg_dis |=> led_full_out == !$past(dup_s) && led_100m_out == !$past(spd_s);
  endproperty
  a_straps: assert property (p_straps) else $error("strap speed/duplex not applied");
  property p_mdi_fixed;
    @(posedge clk_in) disable iff (rst_in) !xo_en |=> !mdix_select_out;
  endproperty
  a_mdi_fixed: assert property (p_mdi_fixed) else $error("crossover active with strap off");
  property p_split;
    @(posedge clk_in) disable iff (rst_in) lan_to_wan_pkts_out + wan_to_lan_pkts_out <= lwb_pkg::TOTAL_PKT_BUF;
  endproperty
  a_split: assert property (p_split) else $error("buffer split exceeds total");
  property p_pad;
    @(posedge clk_in) disable iff (rst_in) lan_tx_valid_out && lan_tx_last_out |-> pcnt_q == 11'h000 && !pad_q;
  endproperty
  a_pad: assert property (p_pad) else $error("pad state wrong at frame end");
  property p_flags;
    @(posedge clk_in) disable iff (rst_in) $rose(wan_tx_valid_out) |-> wan_tx_data_out == lwb_pkg::HDLC_FLAG;
  endproperty
  a_flags: assert property (p_flags) else $error("wan frame without opening flag");
endmodule : lwb_bridge_top
`default_nettype wire

//--- lwb_pkg.sv
// lwb_pkg: constants, types and hashing shared by the lan/wan bridge files
// assumes a single 100 MHz clock and synchronous active-high reset
`default_nettype none
package lwb_pkg;
  localparam int unsigned CLK_HZ           = 100_000_000;
  localparam int unsigned AGE_TIME_S       = 300;               // 5 minutes
  localparam int unsigned TABLE_ENTRIES    = 256;
  localparam int unsigned TABLE_IDX_W      = 8;
  localparam int unsigned MAC_W            = 48;
  localparam int unsigned BUF_BYTES        = 2048;
  localparam int unsigned BUF_AW           = 11;
  localparam logic [10:0] MIN_FRAME_BYTES  = 11'h03c;           // 60 bytes before fcs
  localparam logic [10:0] HDR_DST_END      = 11'h006;
  localparam logic [10:0] HDR_SRC_END      = 11'h00c;
  localparam logic [7:0]  HDLC_FLAG        = 8'h7e;
  localparam logic [7:0]  HDLC_ESC         = 8'h7d;
  localparam logic [7:0]  HDLC_XOR         = 8'h20;
  localparam logic [8:0]  TOTAL_PKT_BUF    = 9'h154;            // 340
  localparam logic [8:0]  PKT_BUF_LARGE    = 9'h134;            // 308
  localparam logic [8:0]  PKT_BUF_EVEN     = 9'h0aa;            // 170
  localparam logic [8:0]  PKT_BUF_SMALL    = 9'h020;            // 32
  localparam logic [1:0]  MEM_CFG_L2W      = 2'h0;
  localparam logic [1:0]  MEM_CFG_EVEN     = 2'h1;
  localparam logic [1:0]  MEM_CFG_W2L      = 2'h2;

  typedef enum logic [3:0] {
    LWB_TX_IDLE = 4'h1,
    LWB_TX_DATA = 4'h2,
    LWB_TX_ESC  = 4'h4,
    LWB_TX_DONE = 4'h8
  } lwb_tx_state_t;

  // folds a station address into a table index
  function automatic logic [TABLE_IDX_W-1:0] lwb_hash(input logic [MAC_W-1:0] mac);
    lwb_hash = mac[47:40] ^ mac[39:32] ^ mac[31:24] ^ mac[23:16] ^ mac[15:8] ^ mac[7:0];
  endfunction : lwb_hash
endpackage : lwb_pkg
`default_nettype wire

//--- lwb_table_if.sv
// lwb_table_if: lookup and learning signals between bridge core and address table
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface lwb_table_if;
  logic [47:0] lookup_mac;
  logic        lookup_hit;
  logic        learn_valid;
  logic [47:0] learn_mac;
  logic        sec_tick;
  modport table_end  (input lookup_mac, learn_valid, learn_mac, sec_tick, output lookup_hit);
  modport bridge_end (output lookup_mac, learn_valid, learn_mac, sec_tick, input lookup_hit);
endinterface : lwb_table_if
`default_nettype wire

//--- lwb_mac_table.sv
// lwb_mac_table: 256-entry learned address table with aging sweep
// assumes sec_tick is a one-cycle pulse once per second
`timescale 1ns/1ps
`default_nettype none
module lwb_mac_table (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  lwb_table_if.table_end    tbl
);
  logic [47:0] mac_mem [lwb_pkg::TABLE_ENTRIES];
  logic [lwb_pkg::TABLE_ENTRIES-1:0] valid_q;
  logic [lwb_pkg::TABLE_ENTRIES-1:0] fresh_q;
  logic [8:0]  sec_cnt_q;
  logic        sweep_q;
  logic [7:0]  sweep_idx_q;
  logic [7:0]  look_idx;
  logic [7:0]  learn_idx;
  logic        age_due;

  assign look_idx       = lwb_pkg::lwb_hash(tbl.lookup_mac);
  assign learn_idx      = lwb_pkg::lwb_hash(tbl.learn_mac);
  assign tbl.lookup_hit = valid_q[look_idx] && (mac_mem[look_idx] == tbl.lookup_mac);
  assign age_due        = tbl.sec_tick && (sec_cnt_q == 9'(lwb_pkg::AGE_TIME_S - 1));

  always_ff @(posedge clk_in) begin
    if (tbl.learn_valid) begin
      mac_mem[learn_idx] <= tbl.learn_mac;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      valid_q     <= '0;
      fresh_q     <= '0;
      sec_cnt_q   <= 9'h000;
      sweep_q     <= 1'b0;
      sweep_idx_q <= 8'h00;
    end else begin
      if (tbl.sec_tick) begin
        sec_cnt_q <= age_due ? 9'h000 : sec_cnt_q + 9'h001;
      end
      if (age_due) begin
        sweep_q <= 1'b1;
      end else if (sweep_q) begin
        // stale entries go, survivors must be refreshed before the next pass
        if (!fresh_q[sweep_idx_q]) begin
          valid_q[sweep_idx_q] <= 1'b0;
        end
        fresh_q[sweep_idx_q] <= 1'b0;
        sweep_idx_q          <= sweep_idx_q + 8'h01;
        sweep_q              <= (sweep_idx_q != 8'hff);
      end
      // a learn wins over the sweep on the same entry
      if (tbl.learn_valid) begin
        valid_q[learn_idx] <= 1'b1;
        fresh_q[learn_idx] <= 1'b1;
      end
    end
  end

  property p_learn_hit;
    @(posedge clk_in) disable iff (rst_in)
    tbl.learn_valid ##1 (tbl.lookup_mac == $past(tbl.learn_mac)) |-> tbl.lookup_hit;
  endproperty
  a_learn_hit: assert property (p_learn_hit) else $error("learned address not found");

  property p_sweep_len;
    @(posedge clk_in) disable iff (rst_in)
    $rose(sweep_q) |-> sweep_q [*8] ##[1:260] !sweep_q;
  endproperty
  a_sweep_len: assert property (p_sweep_len) else $error("aging sweep length wrong");
endmodule : lwb_mac_table
`default_nettype wire

//--- lwb_link_partner.sv
// lwb_link_partner: behavioural twisted-pair station seen through phy status pins and lan tx acceptance
// assumes the bench sets the station's abilities and the bridge clock paces it
`timescale 1ns/1ps
`default_nettype none
module lwb_link_partner (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic link_up_in,
  input  wire logic can_neg_in,
  input  wire logic adv_100_in,
  input  wire logic adv_full_in,
  input  wire logic pol_rev_in,
  input  wire logic slow_in,
  input  wire logic an_enable_in,
  output logic      phy_link_out,
  output logic      an_done_out,
  output logic      an_ok_out,
  output logic      an_speed100_out,
  output logic      an_full_out,
  output logic      pol_reversed_out,
  output logic      lan_tx_ready_out
);
  logic [3:0] neg_q;
  logic       pace_q;
  always_ff @(posedge clk_in) begin
    if (rst_in || !link_up_in || !an_enable_in) neg_q <= 4'h0;
    else if (neg_q != 4'hf) neg_q <= neg_q + 4'h1;
    pace_q <= rst_in ? 1'b0 : !pace_q;
  end
  // exchange takes 15 cycles; a legacy station finishes but never agrees
  assign an_done_out      = neg_q == 4'hf;
  assign an_ok_out        = an_done_out && can_neg_in;
  // ability bits carry junk while no agreement stands
  assign an_speed100_out  = an_ok_out ? adv_100_in : pace_q;
  assign an_full_out      = an_ok_out ? adv_full_in : !pace_q;
  assign phy_link_out     = link_up_in;
  assign pol_reversed_out = pol_rev_in;
  // a slow station accepts every other cycle
  assign lan_tx_ready_out = slow_in ? pace_q : 1'b1;
endmodule : lwb_link_partner
`default_nettype wire

//--- lwb_bridge_top_bench.sv
// lwb_bridge_top_bench: self-checking bench for the lan/wan bridge
// assumes the package and interface compile before the modules
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, sn) \
  begin \
    tests_run++; \
    if ((sn) !== (ex)) begin \
      err_count++; \
      $display("Error %s expected %h seen %h", nm, ex, sn); \
    end \
  end
module lwb_bridge_top_bench;
  localparam int unsigned SEC   = 20;
  localparam logic [47:0] STA_A = 48'h02_00_00_00_00_0a;
  localparam logic [47:0] STA_B = 48'h02_00_00_00_00_0b;
  localparam logic [47:0] STA_C = 48'h02_00_00_00_00_0c;
  localparam logic [7:0]  PAY [4] = '{8'h7e, 8'h11, 8'h7d, 8'h22};
  localparam logic [7:0]  WPAY [3] = '{8'ha5, 8'h7e, 8'h01};
  logic clk_in = 1'b0, rst_in = 1'b1, wan_tx_ready_in = 1'b1;
  logic filter_enable_strap_in = 1'b0, flow_control_strap_in = 1'b0, negotiation_disable_strap_in = 1'b0;
  logic duplex_select_strap_in = 1'b0, speed_select_strap_in = 1'b0, crossover_auto_strap_in = 1'b0;
  logic [1:0] memory_strap_in = 2'h0;
  logic lan_rx_valid_in = 1'b0, lan_rx_last_in = 1'b0, lan_rx_error_in = 1'b0;
  logic wan_rx_valid_in = 1'b0, wan_rx_last_in = 1'b0;
  logic [7:0] lan_rx_data_in = 8'h00, wan_rx_data_in = 8'h00;
  logic link_up = 1'b1, can_neg = 1'b1, adv_100 = 1'b1, adv_full = 1'b1, pol_rev = 1'b0, slow = 1'b0;
  logic phy_link_in, phy_an_done_in, phy_an_ok_in, phy_an_speed100_in, phy_an_full_in, phy_pol_reversed_in;
  logic lan_tx_ready_in, wan_tx_valid_out, wan_rx_ready_out, lan_tx_valid_out, lan_tx_last_out;
  logic [7:0] wan_tx_data_out, lan_tx_data_out;
  logic an_enable_out, mdix_select_out, pol_invert_out, pause_request_out, memory_reserved_out;
  logic [8:0] lan_to_wan_pkts_out, wan_to_lan_pkts_out;
  logic led_full_out, led_link_out, led_error_out, led_100m_out, led_rx_out, led_tx_out;
  logic [7:0] frm[$], wq[$], lq[$];
  logic       lk[$];
  int         err_count = 0, tests_run = 0;

  lwb_bridge_top #(.SEC_CYCLES(SEC)) dut (.clk_in, .rst_in, .filter_enable_strap_in, .flow_control_strap_in,
    .negotiation_disable_strap_in, .duplex_select_strap_in, .speed_select_strap_in, .crossover_auto_strap_in,
    .memory_strap_in, .phy_link_in, .phy_an_done_in, .phy_an_ok_in, .phy_an_speed100_in, .phy_an_full_in,
    .phy_pol_reversed_in, .lan_rx_valid_in, .lan_rx_data_in, .lan_rx_last_in, .lan_rx_error_in,
    .wan_tx_valid_out, .wan_tx_data_out, .wan_tx_ready_in, .wan_rx_valid_in, .wan_rx_data_in, .wan_rx_last_in,
    .wan_rx_ready_out, .lan_tx_valid_out, .lan_tx_data_out, .lan_tx_last_out, .lan_tx_ready_in, .an_enable_out,
    .mdix_select_out, .pol_invert_out, .pause_request_out, .lan_to_wan_pkts_out, .wan_to_lan_pkts_out,
    .memory_reserved_out, .led_full_out, .led_link_out, .led_error_out, .led_100m_out, .led_rx_out, .led_tx_out);

  lwb_link_partner peer (.clk_in, .rst_in, .link_up_in(link_up), .can_neg_in(can_neg), .adv_100_in(adv_100),
    .adv_full_in(adv_full), .pol_rev_in(pol_rev), .slow_in(slow), .an_enable_in(an_enable_out),
    .phy_link_out(phy_link_in), .an_done_out(phy_an_done_in), .an_ok_out(phy_an_ok_in),
    .an_speed100_out(phy_an_speed100_in), .an_full_out(phy_an_full_in),
    .pol_reversed_out(phy_pol_reversed_in), .lan_tx_ready_out(lan_tx_ready_in));

  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    if (wan_tx_valid_out && wan_tx_ready_in) wq.push_back(wan_tx_data_out);
    if (lan_tx_valid_out && lan_tx_ready_in) begin
      lq.push_back(lan_tx_data_out);
      lk.push_back(lan_tx_last_out);
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  task automatic wait_fail(input string nm);
    err_count++;
    $display("Error %s expected done seen timeout", nm);
    give_verdict();
  endtask : wait_fail

  task automatic mk_frame(input logic [47:0] dst, input logic [47:0] src);
    frm = {};
    for (int i = 5; i >= 0; i--) frm.push_back(dst[i*8 +: 8]);
    for (int i = 5; i >= 0; i--) frm.push_back(src[i*8 +: 8]);
    foreach (PAY[i]) frm.push_back(PAY[i]);
  endtask : mk_frame

  task automatic send_lan(input logic err);
    wq = {};
    foreach (frm[i]) begin
      lan_rx_valid_in = 1'b1;
      lan_rx_data_in  = frm[i];
      lan_rx_last_in  = (i == frm.size() - 1);
      lan_rx_error_in = err && lan_rx_last_in;
      tick(1);
    end
    lan_rx_valid_in = 1'b0;
    lan_rx_last_in  = 1'b0;
    lan_rx_error_in = 1'b0;
  endtask : send_lan

  task automatic expect_wan(input logic drop);
    logic [7:0] ex[$];
    int         k;
    ex = {};
    k  = 0;
    if (!drop) begin
      ex.push_back(lwb_pkg::HDLC_FLAG);
      foreach (frm[i]) begin
        if (frm[i] == lwb_pkg::HDLC_FLAG || frm[i] == lwb_pkg::HDLC_ESC) begin
          ex.push_back(lwb_pkg::HDLC_ESC);
          ex.push_back(frm[i] ^ lwb_pkg::HDLC_XOR);
        end else ex.push_back(frm[i]);
      end
      ex.push_back(lwb_pkg::HDLC_FLAG);
    end
    while (wq.size() < ex.size() && k < 300) begin
      tick(1);
      k++;
    end
    if (wq.size() < ex.size()) wait_fail("wan_frame");
    tick(100);
    `CHK("wan_len", ex.size(), wq.size())
    foreach (ex[i]) `CHK("wan_byte", ex[i], wq[i])
  endtask : expect_wan

  task automatic t_split();
    logic [8:0] l2w, w2l;
    for (int m = 0; m < 4; m++) begin
      memory_strap_in = m[1:0];
      tick(8);
      l2w = (m == 0) ? lwb_pkg::PKT_BUF_LARGE : (m == 1) ? lwb_pkg::PKT_BUF_EVEN : lwb_pkg::PKT_BUF_SMALL;
      w2l = (m == 0) ? lwb_pkg::PKT_BUF_SMALL : (m == 1) ? lwb_pkg::PKT_BUF_EVEN : lwb_pkg::PKT_BUF_LARGE;
      `CHK("l2w_pkts", l2w, lan_to_wan_pkts_out)
      `CHK("w2l_pkts", w2l, wan_to_lan_pkts_out)
      `CHK("pkt_total", 1'b1, (lan_to_wan_pkts_out + wan_to_lan_pkts_out) <= lwb_pkg::TOTAL_PKT_BUF)
      `CHK("mem_reserved", (m == 3), memory_reserved_out)
    end
    memory_strap_in = 2'h0;
    $display("split test done");
  endtask : t_split

  task automatic t_mode();
    negotiation_disable_strap_in = 1'b1;
    for (int m = 0; m < 4; m++) begin
      duplex_select_strap_in = m[0];
      speed_select_strap_in  = m[1];
      tick(8);
      `CHK("an_enable", 1'b0, an_enable_out)
      `CHK("led_full", !m[0], led_full_out)
      `CHK("led_100m", !m[1], led_100m_out)
      `CHK("led_link", 1'b1, led_link_out)
    end
    negotiation_disable_strap_in = 1'b0;
    tick(40);
    `CHK("an_enable", 1'b1, an_enable_out)
    `CHK("led_full", 1'b1, led_full_out)
    `CHK("led_100m", 1'b1, led_100m_out)
    can_neg = 1'b0;
    tick(8);
    `CHK("led_full", 1'b0, led_full_out)
    `CHK("led_100m", 1'b0, led_100m_out)
    $display("link mode test done");
  endtask : t_mode

  task automatic t_xover();
    int   n;
    logic prev;
    link_up = 1'b0;
    tick(8);
    `CHK("led_link", 1'b0, led_link_out)
    n = 0;
    repeat (100) begin
      n += mdix_select_out;
      tick(1);
    end
    `CHK("mdix_fixed", 0, n)
    crossover_auto_strap_in = 1'b1;
    tick(4);
    n    = 0;
    prev = mdix_select_out;
    repeat (100) begin
      tick(1);
      if (mdix_select_out !== prev) n++;
      prev = mdix_select_out;
    end
    `CHK("mdix_hunt", 1'b1, n >= 4 && n <= 6)
    link_up = 1'b1;
    pol_rev = 1'b1;
    tick(8);
    `CHK("pol_invert", 1'b1, pol_invert_out)
    pol_rev = 1'b0;
    tick(8);
    `CHK("pol_invert", 1'b0, pol_invert_out)
    $display("crossover test done");
  endtask : t_xover

  task automatic t_fwd_off();
    mk_frame(STA_B, STA_A);
    send_lan(1'b0);
    expect_wan(1'b0);
    mk_frame(STA_A, STA_C);
    send_lan(1'b0);
    expect_wan(1'b0);
    send_lan(1'b1);
    `CHK("led_error", 1'b1, led_error_out)
    `CHK("led_rx", 1'b1, led_rx_out)
    expect_wan(1'b1);
    $display("repeater test done");
  endtask : t_fwd_off

  task automatic t_fwd_on();
    filter_enable_strap_in = 1'b1;
    tick(8);
    mk_frame(STA_B, STA_A);
    send_lan(1'b0);
    expect_wan(1'b0);
    mk_frame(STA_A, STA_C);
    send_lan(1'b0);
    expect_wan(1'b1);
    tick(4700);
    send_lan(1'b0);
    expect_wan(1'b1);
    tick(7600);
    send_lan(1'b0);
    expect_wan(1'b0);
    $display("filter test done");
  endtask : t_fwd_on

  task automatic t_pad();
    int k;
    slow = 1'b1;
    flow_control_strap_in = 1'b1;
    lq   = {};
    lk   = {};
    foreach (WPAY[i]) begin
      wan_rx_valid_in = 1'b1;
      wan_rx_data_in  = WPAY[i];
      wan_rx_last_in  = (i == 2);
      k = 0;
      while (!wan_rx_ready_out && k < 100) begin
        tick(1);
        k++;
      end
      if (!wan_rx_ready_out) wait_fail("wan_rx_ready");
      tick(1);
    end
    wan_rx_valid_in = 1'b0;
    wan_rx_last_in  = 1'b0;
    k = 0;
    while (lq.size() < 60 && k < 400) begin
      tick(1);
      k++;
    end
    if (lq.size() < 60) wait_fail("lan_frame");
    `CHK("led_tx", 1'b1, led_tx_out)
    tick(20);
    `CHK("lan_len", 60, lq.size())
    foreach (lq[i]) begin
      `CHK("lan_byte", (i < 3) ? WPAY[i] : 8'h00, lq[i])
      `CHK("lan_last", (i == 59), lk[i])
    end
    `CHK("pause_req", 1'b0, pause_request_out)
    $display("padding test done");
  endtask : t_pad

  initial begin
    tick(3);
    `CHK("rst_wan_valid", 1'b0, wan_tx_valid_out)
    rst_in = 1'b0;
    tick(8);
    t_split();
    t_mode();
    t_xover();
    t_fwd_off();
    t_fwd_on();
    t_pad();
    give_verdict();
  end
endmodule : lwb_bridge_top_bench
`default_nettype wire
